/* File: dv/chg_batt_model.sv */
`default_nettype none

// Battery and thermistor seen through ideal comparators; no hysteresis,
// so any glitch filtering seen at the block comes from the design itself
module chg_batt_model #(
  parameter logic [15:0] SHORT_MV = 16'hce4,
  parameter logic [15:0] LOW_MV   = 16'he10,
  parameter logic [7:0]  HOT_C    = 8'h2d,
  parameter logic [7:0]  COLD_C   = 8'h05
) (
  input  wire logic [15:0] vbat_mv,
  input  wire logic [7:0]  temp_c,
  output logic             bat_above_3v,
  output logic             bat_above_short,
  output logic             bat_above_low,
  output logic             temp_hot,
  output logic             temp_cold
);
  timeunit 1ns;
  timeprecision 1ps;
  assign bat_above_3v    = vbat_mv > 16'hbb8;
  assign bat_above_short = vbat_mv > SHORT_MV;
  assign bat_above_low   = vbat_mv > LOW_MV;
  assign temp_hot        = temp_c > HOT_C;
  assign temp_cold       = temp_c < COLD_C;
endmodule : chg_batt_model

`default_nettype wire

/* File: dv/chg_ctrl_tb.sv */
`default_nettype none

module chg_ctrl_tb
  import chg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, reset, ship_control_pin, charge_enable_pin, reverse_power_request_n, ship_cmd;
  logic vin_present, vin_in_range, vin_ov, vin_uv, vbat_present, bat_ov, regulator_fault;
  logic idle_hold, reverse_power_force, regulator_fault_mask, battery_temp_input_en;
  logic bat_above_3v, bat_above_short, bat_above_low, temp_hot, temp_cold;
  logic converter_en, serial_if_en, dead_batt_source_en, short_current_en, precharge_en;
  logic charge_status_n, fast_charge_go, charge_fault, prev;
  logic [1:0]  startup_delay_sel;
  logic [3:0]  short_charge_current, precharge_current_sel, op_mode;
  logic [7:0]  temp_c, charge_state, charge_current_code;
  logic [15:0] vbat_mv;
  int          fail_count, comparisons, n;

  chg_batt_model chg_batt_model_inst (.vbat_mv, .temp_c, .bat_above_3v, .bat_above_short,
    .bat_above_low, .temp_hot, .temp_cold);
  // Shortened counts keep the whole run to under a thousand cycles
  chg_ctrl #(.DB_QUAL_CYC(32'h8), .QUAL_CYC(32'h10), .LB_CYC(64'hc8), .BLINK_HALF_CYC(32'ha),
    .STRT0_CYC(32'h4), .STRT1_CYC(32'h6), .STRT2_CYC(32'h8), .STRT3_CYC(32'ha)) chg_ctrl_inst (
    .core_clk, .reset, .ship_control_pin, .charge_enable_pin, .reverse_power_request_n,
    .vin_present, .vin_in_range, .vin_ov, .vin_uv, .vbat_present, .bat_above_3v, .bat_above_short,
    .bat_above_low, .bat_ov, .temp_hot, .temp_cold, .regulator_fault, .ship_cmd, .idle_hold,
    .reverse_power_force, .startup_delay_sel, .short_charge_current, .precharge_current_sel,
    .regulator_fault_mask, .battery_temp_input_en, .op_mode, .charge_state, .converter_en,
    .serial_if_en, .dead_batt_source_en, .short_current_en, .precharge_en, .charge_current_code,
    .charge_status_n, .fast_charge_go, .charge_fault);

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  // Bounded wait on the mode (m=1) or the charge state (m=0)
  task automatic wait_on(input bit m, input logic [7:0] v, input int lim);
    int k;
    k = 0;
    while ((m ? {4'h0, op_mode} : charge_state) !== v && k < lim) begin
      cyc(1);
      k++;
    end
    check(8'(k < lim), 8'h1);
    if (k >= lim) summarize();
  endtask : wait_on

  task automatic scn_boot();
    check(8'(op_mode), 8'(CHG_MODE_SHIP));
    check(8'({serial_if_en, converter_en}), 8'h0);
    ship_control_pin = 1'b0;
    vin_present = 1'b1;
    wait_on(1'b1, 8'(CHG_MODE_IDLE), 32'h10);
    cyc(32'h14);
    check(8'(op_mode), 8'(CHG_MODE_IDLE));
    check(8'({serial_if_en, converter_en}), 8'h2);
  endtask : scn_boot

  task automatic scn_charge();
    idle_hold = 1'b0;
    wait_on(1'b1, 8'(CHG_MODE_CHARGE), 32'h10);
    reverse_power_request_n = 1'b0;
    wait_on(1'b0, CS_DEAD, 32'h20);
    cyc(32'h10);
    check(8'({charge_state, charge_status_n, dead_batt_source_en}), 8'h9);
    vbat_mv = 16'hc1c;
    wait_on(1'b0, CS_SHORT, 32'h14);
    vbat_mv = 16'hd48;
    cyc(32'h2);
    check(8'({op_mode, short_current_en, charge_status_n}), 8'h22);
    check(charge_current_code, 8'(short_charge_current));
    cyc(32'h6);
    check(charge_state, CS_SHORT);
    wait_on(1'b0, CS_PRE, 32'h14);
    reverse_power_request_n = 1'b1;
    precharge_current_sel = 4'h3;
    cyc(32'h2);
    check(charge_current_code, 8'h3);
    check(8'(precharge_en), 8'h1);
    temp_c = 8'h3c;
    wait_on(1'b0, CS_PRE_HOLD, 32'h8);
    // Long enough that a safety timer which kept running would expire
    n = 0;
    prev = charge_status_n;
    repeat (32'ha0) begin
      cyc(1);
      n += int'(charge_status_n !== prev);
      prev = charge_status_n;
    end
    check(8'({converter_en, n > 32'hc}), 8'h1);
    battery_temp_input_en = 1'b0;
    wait_on(1'b0, CS_PRE, 32'h8);
    vbat_mv = 16'he74;
    wait_on(1'b0, CS_HANDOFF, 32'h20);
    n = 0;
    // The pulse rises on the edge that enters handoff, so sample before stepping
    repeat (4) begin
      n += int'(fast_charge_go === 1'b1);
      cyc(1);
    end
    check(8'(n), 8'h1);
  endtask : scn_charge

  task automatic scn_fault();
    charge_enable_pin = 1'b0;
    wait_on(1'b1, 8'(CHG_MODE_IDLE), 32'h10);
    vbat_mv = 16'hc1c;
    temp_c = 8'h19;
    battery_temp_input_en = 1'b1;
    charge_enable_pin = 1'b1;
    wait_on(1'b0, CS_FAULT, 32'h190);
    cyc(32'h2);
    check(8'({charge_fault, converter_en}), 8'h2);
  endtask : scn_fault

  // Longest startup delay, new short current, masked then unmasked regulator fault
  task automatic scn_trip();
    charge_enable_pin = 1'b0;
    wait_on(1'b1, 8'(CHG_MODE_IDLE), 32'h10);
    {startup_delay_sel, short_charge_current, regulator_fault_mask, regulator_fault} = 8'hf3;
    charge_enable_pin = 1'b1;
    wait_on(1'b1, 8'(CHG_MODE_CHARGE), 32'h10);
    cyc(32'h8);
    check(charge_state, CS_RESET);
    wait_on(1'b0, CS_SHORT, 32'h14);
    cyc(32'h2);
    check({charge_state[3:0], charge_current_code[3:0]}, 8'h4c);
    regulator_fault_mask = 1'b0;
    wait_on(1'b0, CS_FAULT, 32'h4);
  endtask : scn_trip

  task automatic scn_rev();
    charge_enable_pin = 1'b0;
    wait_on(1'b1, 8'(CHG_MODE_IDLE), 32'h10);
    reverse_power_force = 1'b1;
    wait_on(1'b1, 8'(CHG_MODE_REV), 32'h10);
    charge_enable_pin = 1'b1;
    cyc(32'h10);
    check(8'({op_mode, converter_en}), 8'h9);
    ship_cmd = 1'b1;
    cyc(1);
    ship_cmd = 1'b0;
    wait_on(1'b1, 8'(CHG_MODE_SHIP), 32'h8);
  endtask : scn_rev

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    {reset, ship_control_pin, charge_enable_pin, idle_hold, vbat_present, vin_in_range} = 6'h3f;
    {reverse_power_request_n, battery_temp_input_en} = 2'h3;
    {vin_present, vin_ov, vin_uv, bat_ov, regulator_fault, regulator_fault_mask} = 6'h0;
    {ship_cmd, reverse_power_force} = 2'h0;
    startup_delay_sel = 2'h1;
    short_charge_current = 4'h5;
    precharge_current_sel = 4'ha;
    vbat_mv = 16'h3e8;
    temp_c = 8'h19;
    fail_count = 0;
    comparisons = 0;
    cyc(4);
    reset = 1'b0;
    scn_boot();
    scn_charge();
    scn_fault();
    scn_trip();
    scn_rev();
    summarize();
  end
endmodule : chg_ctrl_tb

`default_nettype wire

/* File: src/chg_ctrl.sv */
`include "chg_regs.svh"
`default_nettype none

// What this block does
// - Four top modes: ship, idle, reverse, charge
// - Power-up always starts in ship mode
// - Ship disables all but pin monitor, detector
// - Ship entered by host, pin or powerdown
// - Ship goes idle; idle picks charge/reverse
// - Idle-hold bit keeps block in idle
// - Idle: converter off, serial interface alive
// - Charge mode ignores reverse request pin
// - Reverse on pin or force; ignores enable
// - Reset state, timers cleared, startup delay
// - Status low in reset/dead/short/precondition
// - Dead battery below 3V sources 10mA
// - Leave dead after 256us above 3V
// - Short state applies programmable short current
// - Short exit after 16ms above threshold
// - Low-battery timer accumulates, 2 hour limit
// - Short/precondition faults go to fault state
// - Temperature out of range suspends to hold
// - Disabling temperature input forces hold exit
// - Safety timer pauses during temperature hold
// - Status blinks at 1Hz during hold
// - Precondition applies selectable precharge current
// - Precondition exit after 16ms above low
module chg_ctrl
  import chg_pkg::*;
#(
  parameter int unsigned     SHORT_CUR_W    = 4,
  parameter int unsigned     DB_QUAL_CYC    = `CHG_DB_QUAL_US * `CHG_CLK_MHZ,
  parameter int unsigned     QUAL_CYC       = `CHG_QUAL_MS * `CHG_US_PER_MS * `CHG_CLK_MHZ,
  parameter longint unsigned LB_CYC         = 64'(`CHG_LB_LIMIT_H) * 64'(`CHG_S_PER_H)
                                              * 64'(`CHG_US_PER_S) * 64'(`CHG_CLK_MHZ),
  parameter int unsigned     BLINK_HALF_CYC = `CHG_BLINK_HALF_MS * `CHG_US_PER_MS * `CHG_CLK_MHZ,
  parameter int unsigned     STRT0_CYC      = `CHG_STRT_DLY0_MS * `CHG_US_PER_MS * `CHG_CLK_MHZ,
  parameter int unsigned     STRT1_CYC      = `CHG_STRT_DLY1_MS * `CHG_US_PER_MS * `CHG_CLK_MHZ,
  parameter int unsigned     STRT2_CYC      = `CHG_STRT_DLY2_MS * `CHG_US_PER_MS * `CHG_CLK_MHZ,
  parameter int unsigned     STRT3_CYC      = `CHG_STRT_DLY3_MS * `CHG_US_PER_MS * `CHG_CLK_MHZ
) (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  wire logic                         ship_control_pin,
  input  wire logic                         charge_enable_pin,
  input  wire logic                         reverse_power_request_n,
  input  wire logic                         vin_present,
  input  wire logic                         vin_in_range,
  input  wire logic                         vin_ov,
  input  wire logic                         vin_uv,
  input  wire logic                         vbat_present,
  input  wire logic                         bat_above_3v,
  input  wire logic                         bat_above_short,
  input  wire logic                         bat_above_low,
  input  wire logic                         bat_ov,
  input  wire logic                         temp_hot,
  input  wire logic                         temp_cold,
  input  wire logic                         regulator_fault,
  input  wire logic                         ship_cmd,
  input  wire logic                         idle_hold,
  input  wire logic                         reverse_power_force,
  input  wire logic [`CHG_STRT_SEL_W-1:0]   startup_delay_sel,
  input  wire logic [SHORT_CUR_W-1:0]       short_charge_current,
  input  wire logic [`CHG_PRE_SEL_W-1:0]    precharge_current_sel,
  input  wire logic                         regulator_fault_mask,
  input  wire logic                         battery_temp_input_en,
  output logic      [3:0]                   op_mode,
  output logic      [7:0]                   charge_state,
  output logic                              converter_en,
  output logic                              serial_if_en,
  output logic                              dead_batt_source_en,
  output logic                              short_current_en,
  output logic                              precharge_en,
  output logic      [`CHG_CUR_CODE_W-1:0]   charge_current_code,
  output logic                              charge_status_n,
  output logic                              fast_charge_go,
  output logic                              charge_fault
);

  localparam int unsigned STRT_MAX = (STRT0_CYC > STRT1_CYC ? STRT0_CYC : STRT1_CYC) >
                                     (STRT2_CYC > STRT3_CYC ? STRT2_CYC : STRT3_CYC) ?
                                     (STRT0_CYC > STRT1_CYC ? STRT0_CYC : STRT1_CYC) :
                                     (STRT2_CYC > STRT3_CYC ? STRT2_CYC : STRT3_CYC);
  localparam int unsigned STRT_W  = $clog2(STRT_MAX + 1);
  localparam int unsigned LB_W    = $clog2(LB_CYC + 1);
  localparam int unsigned BLINK_W = $clog2(BLINK_HALF_CYC + 1);
  localparam int unsigned QUAL_W  = $clog2(QUAL_CYC + 1);

  if (SHORT_CUR_W == 0 || SHORT_CUR_W > `CHG_CUR_CODE_W || `CHG_PRE_SEL_W > `CHG_CUR_CODE_W ||
      DB_QUAL_CYC == 0 || QUAL_CYC == 0 || LB_CYC == 0 || BLINK_HALF_CYC == 0) begin : g_chk
    $error("chg_ctrl: unsupported parameter values");
  end

  // Input synchronisation
  logic [14:0] pin_s;
  logic        ship_pin_s;
  logic        chg_en_s;
  logic        rev_n_s;
  logic        vin_s;
  logic        vin_ok_s;
  logic        vin_ov_s;
  logic        vin_uv_s;
  logic        vbat_s;
  logic        bat3_s;
  logic        bat_short_s;
  logic        bat_low_s;
  logic        bat_ov_s;
  logic        hot_s;
  logic        cold_s;
  logic        vreg_flt_s;

  chg_sync #(
    .W       (15),
    .RST_VAL (`CHG_PIN_RST)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .din      ({ship_control_pin, charge_enable_pin, reverse_power_request_n, vin_present,
                vin_in_range, vin_ov, vin_uv, vbat_present, bat_above_3v, bat_above_short,
                bat_above_low, bat_ov, temp_hot, temp_cold, regulator_fault}),
    .dout     (pin_s)
  );

  assign {ship_pin_s, chg_en_s, rev_n_s, vin_s, vin_ok_s, vin_ov_s, vin_uv_s, vbat_s, bat3_s,
          bat_short_s, bat_low_s, bat_ov_s, hot_s, cold_s, vreg_flt_s} = pin_s;

  // Top-level mode machine
  chg_mode_t mode_q;
  chg_mode_t mode_d;
  logic      ship_pin_prev_q;
  logic      vin_prev_q;
  logic      ship_go;
  logic      ship_wake;
  logic      rev_want;
  logic      chg_want;
  logic      chg_keep;

  // Previous levels reset to the synchroniser reset levels, so no false edge at start-up
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ship_pin_prev_q <= 1'b1;
      vin_prev_q      <= 1'b0;
    end else begin
      ship_pin_prev_q <= ship_pin_s;
      vin_prev_q      <= vin_s;
    end
  end

  assign ship_go   = ship_cmd || (ship_pin_s && !ship_pin_prev_q) || (!vin_s && !vbat_s);
  assign ship_wake = (!ship_pin_s && ship_pin_prev_q) || (vin_s && !vin_prev_q);
  assign rev_want  = (!rev_n_s || reverse_power_force) && vbat_s;
  assign chg_want  = chg_en_s && vin_ok_s;
  assign chg_keep  = chg_en_s && vin_s;

  always_comb begin
    mode_d = mode_q;
    if (ship_go) begin
      mode_d = CHG_MODE_SHIP;
    end else begin
      unique case (mode_q)
        CHG_MODE_SHIP: begin
          if (ship_wake) begin
            mode_d = CHG_MODE_IDLE;
          end
        end
        CHG_MODE_IDLE: begin
          if (!idle_hold) begin
            if (chg_want) begin
              mode_d = CHG_MODE_CHARGE;
            end else if (rev_want) begin
              mode_d = CHG_MODE_REV;
            end
          end
        end
        CHG_MODE_REV: begin
          if (idle_hold || !rev_want) begin
            mode_d = CHG_MODE_IDLE;
          end
        end
        CHG_MODE_CHARGE: begin
          if (idle_hold || !chg_keep) begin
            mode_d = CHG_MODE_IDLE;
          end
        end
        default: begin
          mode_d = CHG_MODE_SHIP;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q <= CHG_MODE_SHIP;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Charge state machine
  chg_cstate_t cs_q;
  chg_cstate_t cs_d;
  logic        in_chg;
  logic        temp_bad;
  logic        fault_any;
  logic        strt_done;
  logic        db_done;
  logic        short_done;
  logic        pre_done;
  logic        lb_expired;
  logic        handoff;
  logic        cs_hold;
  logic        cs_run;

  assign in_chg    = (mode_q == CHG_MODE_CHARGE);
  assign temp_bad  = battery_temp_input_en && (hot_s || cold_s);
  assign fault_any = lb_expired || bat_ov_s || vin_ov_s || vin_uv_s ||
                     (vreg_flt_s && !regulator_fault_mask);
  assign cs_hold   = (cs_q == CS_SHORT_HOLD) || (cs_q == CS_PRE_HOLD);
  assign cs_run    = (cs_q == CS_DEAD) || (cs_q == CS_SHORT) || (cs_q == CS_PRE);
  assign handoff   = in_chg && (cs_q == CS_PRE) && (cs_d == CS_HANDOFF);

  always_comb begin
    cs_d = cs_q;
    if (!in_chg) begin
      cs_d = CS_RESET;
    end else begin
      unique case (cs_q)
        CS_RESET: begin
          if (strt_done) begin
            cs_d = CS_DEAD;
          end
        end
        CS_DEAD: begin
          if (db_done) begin
            cs_d = CS_SHORT;
          end
        end
        CS_SHORT: begin
          if (fault_any) begin
            cs_d = CS_FAULT;
          end else if (temp_bad) begin
            cs_d = CS_SHORT_HOLD;
          end else if (short_done) begin
            cs_d = CS_PRE;
          end
        end
        CS_SHORT_HOLD: begin
          if (!temp_bad) begin
            cs_d = CS_SHORT;
          end
        end
        CS_PRE: begin
          if (fault_any) begin
            cs_d = CS_FAULT;
          end else if (temp_bad) begin
            cs_d = CS_PRE_HOLD;
          end else if (pre_done) begin
            cs_d = CS_HANDOFF;
          end
        end
        CS_PRE_HOLD: begin
          if (!temp_bad) begin
            cs_d = CS_PRE;
          end
        end
        CS_HANDOFF, CS_FAULT: begin
          cs_d = cs_q;
        end
        default: begin
          cs_d = CS_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cs_q <= CS_RESET;
    end else begin
      cs_q <= cs_d;
    end
  end

  // Startup delay, counted only while the input is in range
  logic [STRT_W-1:0] strt_cnt_q;
  logic [STRT_W-1:0] strt_lim;

  always_comb begin
    unique case (startup_delay_sel)
      2'h0: strt_lim = STRT_W'(STRT0_CYC);
      2'h1: strt_lim = STRT_W'(STRT1_CYC);
      2'h2: strt_lim = STRT_W'(STRT2_CYC);
      2'h3: strt_lim = STRT_W'(STRT3_CYC);
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset || !in_chg || cs_q != CS_RESET || !vin_ok_s) begin
      strt_cnt_q <= '0;
    end else if (strt_cnt_q < strt_lim) begin
      strt_cnt_q <= strt_cnt_q + STRT_W'(1);
    end
  end

  assign strt_done = vin_ok_s && (strt_cnt_q >= strt_lim);

  // Exit qualifiers restart on every entry, so each state lasts at least its figure
  chg_qual #(.LIMIT(DB_QUAL_CYC)) u_db_qual (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (cs_q != CS_DEAD),
    .cond     (bat3_s),
    .done     (db_done)
  );

  chg_qual #(.LIMIT(QUAL_CYC)) u_short_qual (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (cs_q != CS_SHORT),
    .cond     (bat_short_s),
    .done     (short_done)
  );

  chg_qual #(.LIMIT(QUAL_CYC)) u_pre_qual (
    .core_clk (core_clk),
    .reset    (reset),
    .clr      (cs_q != CS_PRE),
    .cond     (bat_low_s),
    .done     (pre_done)
  );

  // Low-battery safety timer; counts only in running states, so the holds freeze it
  logic [LB_W-1:0] lb_cnt_q;

  always_ff @(posedge core_clk) begin
    if (reset || !in_chg || cs_q == CS_RESET || handoff) begin
      lb_cnt_q <= '0;
    end else if (cs_run && !lb_expired) begin
      lb_cnt_q <= lb_cnt_q + LB_W'(1);
    end
  end

  assign lb_expired = (lb_cnt_q == LB_W'(LB_CYC));

  // Status blink in the temperature holds
  logic [BLINK_W-1:0] blink_cnt_q;
  logic               blink_q;

  always_ff @(posedge core_clk) begin
    if (reset || !in_chg || !cs_hold) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == BLINK_W'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_q <= '0;
      blink_q     <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + BLINK_W'(1);
    end
  end

  // Registered outputs
  logic                       status_n_q;
  logic                       conv_en_q;
  logic                       serial_en_q;
  logic                       dead_src_q;
  logic                       short_en_q;
  logic                       pre_en_q;
  logic [`CHG_CUR_CODE_W-1:0] cur_code_q;
  logic                       go_q;
  logic                       fault_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_n_q <= 1'b1;
    end else if (in_chg && (cs_q == CS_RESET || cs_run)) begin
      status_n_q <= 1'b0;
    end else if (in_chg && cs_hold) begin
      status_n_q <= blink_q;
    end else begin
      status_n_q <= 1'b1;
    end
  end

  // Converter only switches in reverse or active charge phases; holds stop it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_en_q   <= 1'b0;
      serial_en_q <= 1'b0;
    end else begin
      conv_en_q   <= (mode_q == CHG_MODE_REV) ||
                     (in_chg && (cs_q == CS_SHORT || cs_q == CS_PRE || cs_q == CS_HANDOFF));
      serial_en_q <= (mode_q != CHG_MODE_SHIP);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dead_src_q <= 1'b0;
      short_en_q <= 1'b0;
      pre_en_q   <= 1'b0;
      cur_code_q <= '0;
    end else begin
      dead_src_q <= in_chg && (cs_q == CS_DEAD);
      short_en_q <= in_chg && (cs_q == CS_SHORT);
      pre_en_q   <= in_chg && (cs_q == CS_PRE);
      if (in_chg && cs_q == CS_SHORT) begin
        cur_code_q <= `CHG_CUR_CODE_W'(short_charge_current);
      end else if (in_chg && cs_q == CS_PRE) begin
        cur_code_q <= `CHG_CUR_CODE_W'(precharge_current_sel);
      end else begin
        cur_code_q <= '0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      go_q    <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      go_q    <= handoff;
      fault_q <= in_chg && (cs_d == CS_FAULT);
    end
  end

  assign op_mode             = mode_q;
  assign charge_state        = cs_q;
  assign converter_en        = conv_en_q;
  assign serial_if_en        = serial_en_q;
  assign dead_batt_source_en = dead_src_q;
  assign short_current_en    = short_en_q;
  assign precharge_en        = pre_en_q;
  assign charge_current_code = cur_code_q;
  assign charge_status_n     = status_n_q;
  assign fast_charge_go      = go_q;
  assign charge_fault        = fault_q;

  // Checks
  logic [QUAL_W-1:0] short_dwell_q;

  always_ff @(posedge core_clk) begin
    if (reset || cs_q != CS_SHORT) begin
      short_dwell_q <= '0;
    end else if (short_dwell_q != QUAL_W'(QUAL_CYC)) begin
      short_dwell_q <= short_dwell_q + QUAL_W'(1);
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (reset);

  sequence s_pre_exit;
    cs_q == CS_PRE ##1 cs_q == CS_HANDOFF;
  endsequence

  sequence s_short_exit;
    in_chg && cs_q == CS_SHORT && cs_d == CS_PRE;
  endsequence

  AST_START_SHIP: assert property ($fell(reset) |-> mode_q == CHG_MODE_SHIP)
    else $error("mode after reset is not ship");
  AST_ONE_MODE: assert property ($onehot(mode_q))
    else $error("mode is not one of the four");
  AST_SHIP_CMD: assert property (ship_cmd |=> mode_q == CHG_MODE_SHIP)
    else $error("ship command did not enter ship");
  AST_SHIP_SERIAL: assert property (mode_q == CHG_MODE_SHIP |=> !serial_if_en && !converter_en)
    else $error("ship mode left a function enabled");
  AST_IDLE_HOLD: assert property (mode_q == CHG_MODE_IDLE && idle_hold && !ship_go
                                  |=> mode_q == CHG_MODE_IDLE)
    else $error("idle hold did not keep idle");
  AST_CHG_KEEP: assert property (in_chg && !ship_go && !idle_hold && chg_keep
                                 |=> in_chg)
    else $error("charge mode left while enabled");
  AST_REV_KEEP: assert property (mode_q == CHG_MODE_REV && !ship_go && !idle_hold && rev_want
                                 |=> mode_q == CHG_MODE_REV)
    else $error("reverse mode left while requested");
  AST_STATUS_LOW: assert property (in_chg && (cs_q == CS_RESET || cs_run) |=> !charge_status_n)
    else $error("status not low while charging");
  AST_FAULT: assert property (in_chg && (cs_q == CS_SHORT || cs_q == CS_PRE) && fault_any
                              |=> cs_q == CS_FAULT ##1 charge_fault)
    else $error("fault did not reach fault state");
  AST_LB_PAUSE: assert property (in_chg && cs_hold |=> $stable(lb_cnt_q))
    else $error("safety timer moved during hold");
  AST_TEMP_BACK: assert property (in_chg && cs_q == CS_PRE_HOLD && !temp_bad |=> cs_q == CS_PRE)
    else $error("hold did not return to parent");
  AST_SHORT_MIN: assert property (s_short_exit |-> short_dwell_q == QUAL_W'(QUAL_CYC))
    else $error("short state left before its dwell");
  AST_HANDOFF: assert property (s_pre_exit |-> fast_charge_go && lb_cnt_q == '0 ##1 !fast_charge_go)
    else $error("handoff pulse or timer clear wrong");

endmodule : chg_ctrl

`default_nettype wire

/* File: src/chg_pkg.sv */
`default_nettype none

package chg_pkg;

  typedef enum logic [3:0] {
    CHG_MODE_SHIP   = 4'h1,
    CHG_MODE_IDLE   = 4'h2,
    CHG_MODE_REV    = 4'h4,
    CHG_MODE_CHARGE = 4'h8
  } chg_mode_t;

  typedef enum logic [7:0] {
    CS_RESET      = 8'h01,
    CS_DEAD       = 8'h02,
    CS_SHORT      = 8'h04,
    CS_SHORT_HOLD = 8'h08,
    CS_PRE        = 8'h10,
    CS_PRE_HOLD   = 8'h20,
    CS_HANDOFF    = 8'h40,
    CS_FAULT      = 8'h80
  } chg_cstate_t;

endpackage : chg_pkg

`default_nettype wire

/* File: src/chg_qual.sv */
`default_nettype none

// Counts consecutive cycles of cond; done once LIMIT cycles are seen
module chg_qual #(
  parameter int unsigned LIMIT = 1
) (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic clr,
  input  wire logic cond,
  output logic      done
);

  localparam int unsigned CW = $clog2(LIMIT + 1);

  if (LIMIT == 0) begin : g_chk
    $error("chg_qual: LIMIT must be at least 1");
  end

  logic [CW-1:0] cnt_q;

  always_ff @(posedge core_clk) begin
    if (reset || clr || !cond) begin
      cnt_q <= '0;
    end else if (cnt_q != CW'(LIMIT)) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign done = (cnt_q == CW'(LIMIT));

endmodule : chg_qual

`default_nettype wire

/* File: src/chg_regs.svh */
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH

// Core clock rate
`define CHG_CLK_MHZ        32'h64
`define CHG_US_PER_MS      32'h3e8
`define CHG_US_PER_S       32'hf4240
`define CHG_S_PER_H        32'he10

// Dead-battery exit qualification, 256 us
`define CHG_DB_QUAL_US     32'h100
// Short and precondition exit qualification, 16 ms
`define CHG_QUAL_MS        32'h10
// Low-battery safety timer limit, 2 hours
`define CHG_LB_LIMIT_H     32'h2
// Status blink at 1 Hz: half period of 500 ms
`define CHG_BLINK_HALF_MS  32'h1f4

// Startup delay per select code, in ms
`define CHG_STRT_DLY0_MS   32'ha
`define CHG_STRT_DLY1_MS   32'h64
`define CHG_STRT_DLY2_MS   32'hc8
`define CHG_STRT_DLY3_MS   32'h190

// Field widths
`define CHG_STRT_SEL_W     2
`define CHG_PRE_SEL_W      4
`define CHG_CUR_CODE_W     8

// Synchroniser reset levels: ship pin high, reverse request idle high
`define CHG_PIN_RST        15'h5000

`endif

/* File: src/chg_sync.sv */
`default_nettype none

// Three-stage input synchroniser; output follows once stages two and three agree
module chg_sync #(
  parameter int unsigned     W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic [W-1:0]  din,
  output logic      [W-1:0]  dout
);

  if (W == 0) begin : g_chk
    $error("chg_sync: W must be at least 1");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;
    always_ff @(posedge core_clk) begin
      if (reset) begin
        s1_q  <= RST_VAL[i];
        s2_q  <= RST_VAL[i];
        s3_q  <= RST_VAL[i];
        out_q <= RST_VAL[i];
      end else begin
        s1_q <= din[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          out_q <= s3_q;
        end
      end
    end
    assign dout[i] = out_q;
  end

endmodule : chg_sync

`default_nettype wire
